// ---- design/pmw_pkg.sv ----
// Package of constants and types for the power-up mode and watchdog block
package pmw_pkg;
	// ============================================================
	// Clock and timing
	localparam int CLK_MHZ = 125;
	localparam int MS_TICK_US = 1000;
	localparam int MS_TICK_CYCLES = CLK_MHZ * MS_TICK_US;
	localparam int SEC_TICK_MS = 1000;
	localparam int WDOG_MIN_MS = 10;
	localparam int WDOG_MAX_MS = 2550;
	localparam logic [11:0] WDOG_DEFAULT_MS = 12'h0C8;
	localparam int WDOG_W = 12;
	// Seconds in about a century: 100 * 365.25 * 86400
	localparam logic [31:0] SEC_WRAP = 32'hBC191380;

	// ============================================================
	// Settings encodings
	typedef enum logic [1:0] {
		PMW_SRC_ALWAYS_FLASH = 2'h0,
		PMW_SRC_COND_FLASH = 2'h1,
		PMW_SRC_ALWAYS_RAM = 2'h2,
		PMW_SRC_NONE = 2'h3
	} pmw_src_t;

	typedef enum logic [1:0] {
		PMW_PU_RUN = 2'h0,
		PMW_PU_STOP = 2'h1,
		PMW_PU_LAST = 2'h2
	} pmw_pumode_t;

	// Switch position and operating mode share one scale, least restrictive first
	typedef enum logic [2:0] {
		PMW_RUN_EN = 3'h0,
		PMW_RUN_DIS = 3'h1,
		PMW_STOP_EN = 3'h2,
		PMW_STOP_DIS = 3'h3,
		PMW_STOP_HALT = 3'h4
	} pmw_mode_t;

	typedef enum logic [1:0] {
		PMW_ORG_FLASH = 2'h0,
		PMW_ORG_RAM = 2'h1,
		PMW_ORG_DEFAULT = 2'h2
	} pmw_origin_t;

	// ============================================================
	// Sequencer states
	typedef enum logic [3:0] {
		PMW_ST_RESET = 4'h1,
		PMW_ST_DECIDE = 4'h2,
		PMW_ST_RUN = 4'h4,
		PMW_ST_HALT = 4'h8
	} pmw_state_t;
endpackage

// ---- design/pmw_tick_div.sv ----
// Cycle divider that issues a one-cycle enable every DIV cycles
`timescale 1ns/1ps
module pmw_tick_div #(
	parameter int DIV = 125000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Tick
	output logic tick
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// ============================================================
	// Next count, wraps at DIV-1
	always_comb begin
		cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = (cnt_q == LAST);
endmodule

// ---- design/powerup_mode_watchdog.sv ----
// Power-up origin and mode selection, elapsed seconds and sweep watchdog
// ============================================================
`timescale 1ns/1ps
module powerup_mode_watchdog #(parameter int MS_CYCLES = pmw_pkg::MS_TICK_CYCLES) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Stored settings, sampled once at power-up
	input wire logic [1:0] flashSrc,
	input wire logic [1:0] ramSrc,
	input wire logic memPreserved,
	input wire logic ramHasConfig,
	input wire logic [1:0] powerupMode,
	input wire logic switchEnable,
	input wire logic [2:0] switchPos,
	input wire logic stopIoScanEn,
	input wire logic [2:0] savedMode,
	input wire logic [11:0] wdogTimeoutMs,
	input wire logic wdogUseDefault,
	// Sweep activity
	input wire logic sweepStart,
	// Results
	output logic decided,
	output logic [1:0] origin,
	output logic [2:0] cpuMode,
	output logic runProgram,
	output logic ioScan,
	output logic outputsEnabled,
	output logic programmerOnly,
	output logic healthLed,
	output logic faultLog,
	output logic [31:0] elapsedSec
);
	// ============================================================
	// Reset release through two flip-flops
	logic rstMeta_q;
	logic rstN_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN_q <= rstMeta_q;
		end
	end

	// ============================================================
	// Millisecond enable
	logic msTick;
	pmw_tick_div #(.DIV(MS_CYCLES)) u_ms ( // A short tick lets a bench reach the slow timers
		.clk(ref_clk),
		.rstN(rstN_q),
		.tick(msTick)
	);

	// Stricter of two modes on the shared scale
	function automatic logic [2:0] stricter(input logic [2:0] a, input logic [2:0] b);
		stricter = (a > b) ? a : b;
	endfunction

	// Stop result is stop-enabled only with stop-mode scanning on
	function automatic logic [2:0] stopScan(input logic [2:0] m, input logic scan);
		stopScan = (m == pmw_pkg::PMW_STOP_EN && !scan) ? 3'(pmw_pkg::PMW_STOP_DIS) : m;
	endfunction

	// ============================================================
	// Origin and mode decision, pure function of the settings
	logic [1:0] orgC;
	logic [2:0] modeC;
	always_comb begin
		orgC = pmw_pkg::PMW_ORG_RAM;
		case (flashSrc)
			pmw_pkg::PMW_SRC_ALWAYS_FLASH: begin
				orgC = pmw_pkg::PMW_ORG_FLASH;
			end
			pmw_pkg::PMW_SRC_COND_FLASH: begin
				if (!memPreserved) begin
					orgC = pmw_pkg::PMW_ORG_FLASH;
				end else if (!ramHasConfig) begin
					orgC = pmw_pkg::PMW_ORG_DEFAULT;
				end
			end
			pmw_pkg::PMW_SRC_ALWAYS_RAM: begin
				if (!memPreserved || !ramHasConfig) begin
					orgC = pmw_pkg::PMW_ORG_DEFAULT;
				end else if (ramSrc == pmw_pkg::PMW_SRC_ALWAYS_FLASH) begin
					orgC = pmw_pkg::PMW_ORG_FLASH;
				end
			end
			default: begin
				if (!memPreserved || !ramHasConfig) begin
					orgC = pmw_pkg::PMW_ORG_DEFAULT;
				end
			end
		endcase
		modeC = pmw_pkg::PMW_STOP_DIS;
		if (orgC == pmw_pkg::PMW_ORG_DEFAULT) begin
			modeC = pmw_pkg::PMW_STOP_DIS;
		end else if (orgC == pmw_pkg::PMW_ORG_FLASH || !memPreserved) begin
			// Flash load or lost memory: stop never scans here
			if (powerupMode == pmw_pkg::PMW_PU_STOP) begin
				modeC = pmw_pkg::PMW_STOP_DIS;
			end else if (!switchEnable) begin
				modeC = pmw_pkg::PMW_RUN_DIS;
			end else if (switchPos == pmw_pkg::PMW_RUN_EN) begin
				modeC = (powerupMode == pmw_pkg::PMW_PU_LAST) ? 3'(pmw_pkg::PMW_RUN_DIS) : switchPos;
			end else if (switchPos == pmw_pkg::PMW_RUN_DIS) begin
				modeC = pmw_pkg::PMW_RUN_DIS;
			end else begin
				modeC = pmw_pkg::PMW_STOP_DIS;
			end
		end else if (powerupMode == pmw_pkg::PMW_PU_STOP) begin
			modeC = stopScan(pmw_pkg::PMW_STOP_EN, stopIoScanEn);
		end else if (powerupMode == pmw_pkg::PMW_PU_RUN) begin
			if (!switchEnable) begin
				modeC = pmw_pkg::PMW_RUN_EN;
			end else if (switchPos >= pmw_pkg::PMW_STOP_EN) begin
				modeC = stopScan(pmw_pkg::PMW_STOP_EN, stopIoScanEn);
			end else begin
				modeC = switchPos;
			end
		end else begin
			// Switch stop position counts as stop-enabled before the scan check
			modeC = switchEnable ? stricter(savedMode, (switchPos >= pmw_pkg::PMW_STOP_EN) ?
				3'(pmw_pkg::PMW_STOP_EN) : switchPos) : savedMode;
			modeC = stopScan((modeC >= pmw_pkg::PMW_STOP_DIS) ? 3'(pmw_pkg::PMW_STOP_DIS) : modeC,
				stopIoScanEn);
		end
	end

	// ============================================================
	// Sequencer with latched decision, watchdog and seconds
	pmw_pkg::pmw_state_t st_q, st_d;
	logic [1:0] org_q, org_d;
	logic [2:0] mode_q, mode_d;
	logic [11:0] wdLim_q, wdLim_d;
	logic [11:0] wdCnt_q, wdCnt_d;
	logic [9:0] msCnt_q, msCnt_d;
	logic [31:0] sec_q, sec_d;
	logic [7:0] blink_q, blink_d;
	logic led_q, led_d;
	logic fault_q, fault_d;
	logic wdExpire;
	logic [11:0] limC;

	// Out-of-range timeouts are clamped; the sweep length margin is software's task
	always_comb begin
		limC = wdogTimeoutMs;
		if (wdogUseDefault) begin
			limC = pmw_pkg::WDOG_DEFAULT_MS;
		end else if (wdogTimeoutMs < 12'(pmw_pkg::WDOG_MIN_MS)) begin
			limC = 12'(pmw_pkg::WDOG_MIN_MS);
		end else if (wdogTimeoutMs > 12'(pmw_pkg::WDOG_MAX_MS)) begin
			limC = 12'(pmw_pkg::WDOG_MAX_MS);
		end
	end

	assign wdExpire = (st_q == pmw_pkg::PMW_ST_RUN) && msTick && !sweepStart && (wdCnt_q >= wdLim_q);

	always_comb begin
		st_d = st_q;
		org_d = org_q;
		mode_d = mode_q;
		wdLim_d = wdLim_q;
		wdCnt_d = wdCnt_q;
		fault_d = 1'b0;
		blink_d = blink_q;
		led_d = led_q;
		// Seconds run from reset with no other write path
		msCnt_d = msCnt_q;
		sec_d = sec_q;
		if (msTick) begin
			if (msCnt_q == 10'(pmw_pkg::SEC_TICK_MS - 1)) begin
				msCnt_d = '0;
				sec_d = (sec_q == pmw_pkg::SEC_WRAP - 1) ? '0 : sec_q + 32'h00000001;
			end else begin
				msCnt_d = msCnt_q + 10'h001;
			end
		end
		case (st_q)
			pmw_pkg::PMW_ST_RESET: begin
				st_d = pmw_pkg::PMW_ST_DECIDE;
			end
			pmw_pkg::PMW_ST_DECIDE: begin
				org_d = orgC;
				mode_d = modeC;
				wdLim_d = limC;
				wdCnt_d = '0;
				led_d = 1'b1;
				st_d = pmw_pkg::PMW_ST_RUN;
			end
			pmw_pkg::PMW_ST_RUN: begin
				// Interrupt work does not pause the count
				if (sweepStart) begin
					wdCnt_d = '0;
				end else if (msTick) begin
					wdCnt_d = wdCnt_q + 12'h001;
				end
				if (wdExpire) begin
					st_d = pmw_pkg::PMW_ST_HALT;
					mode_d = pmw_pkg::PMW_STOP_HALT;
					fault_d = 1'b1;
				end
			end
			pmw_pkg::PMW_ST_HALT: begin
				// Only reset leaves this state
				if (msTick) begin
					blink_d = blink_q + 8'h01;
					if (blink_q == 8'hF9) begin
						blink_d = '0;
						led_d = !led_q;
					end
				end
			end
			default: begin
				st_d = pmw_pkg::PMW_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			st_q <= pmw_pkg::PMW_ST_RESET;
			org_q <= pmw_pkg::PMW_ORG_DEFAULT;
			mode_q <= pmw_pkg::PMW_STOP_DIS;
			wdLim_q <= pmw_pkg::WDOG_DEFAULT_MS;
			wdCnt_q <= '0;
			msCnt_q <= '0;
			sec_q <= '0;
			blink_q <= '0;
			led_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			st_q <= st_d;
			org_q <= org_d;
			mode_q <= mode_d;
			wdLim_q <= wdLim_d;
			wdCnt_q <= wdCnt_d;
			msCnt_q <= msCnt_d;
			sec_q <= sec_d;
			blink_q <= blink_d;
			led_q <= led_d;
			fault_q <= fault_d;
		end
	end

	// ============================================================
	// Outputs decoded from the registered state and mode
	assign decided = (st_q == pmw_pkg::PMW_ST_RUN) || (st_q == pmw_pkg::PMW_ST_HALT);
	assign origin = org_q;
	assign cpuMode = mode_q;
	assign runProgram = decided && (mode_q <= pmw_pkg::PMW_RUN_DIS);
	assign ioScan = decided && (mode_q <= pmw_pkg::PMW_STOP_EN);
	assign outputsEnabled = decided && (mode_q == pmw_pkg::PMW_RUN_EN || mode_q == pmw_pkg::PMW_STOP_EN);
	assign programmerOnly = (st_q == pmw_pkg::PMW_ST_HALT);
	assign healthLed = led_q;
	assign faultLog = fault_q;
	assign elapsedSec = sec_q;

	// ============================================================
	// Checks
	a_halt_sticky: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		programmerOnly |=> programmerOnly && cpuMode == pmw_pkg::PMW_STOP_HALT) else $error("halt left");
	a_expire_halts: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		wdExpire |=> faultLog && programmerOnly && !outputsEnabled) else $error("no halt on expiry");
	a_sweep_clears: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		(st_q == pmw_pkg::PMW_ST_RUN && sweepStart) |=> wdCnt_q == 12'h000) else $error("wdog not cleared");
	a_wdog_counts: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		(st_q == pmw_pkg::PMW_ST_RUN && msTick && !sweepStart && !wdExpire)
		|=> wdCnt_q == $past(wdCnt_q) + 12'h001) else $error("wdog not counting");
	a_limit_range: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		decided |-> (wdLim_q >= 12'h00A && wdLim_q <= 12'h9F6)) else $error("timeout out of range");
	a_stopdis_idle: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		(cpuMode == pmw_pkg::PMW_STOP_DIS) |-> !runProgram && !ioScan) else $error("stop-disabled active");
	a_sec_steps: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		!(msTick && msCnt_q == 10'h3E7) |=> $stable(elapsedSec)) else $error("seconds moved off tick");
	a_always_flash: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		(st_q == pmw_pkg::PMW_ST_DECIDE && flashSrc == pmw_pkg::PMW_SRC_ALWAYS_FLASH)
		|=> origin == pmw_pkg::PMW_ORG_FLASH) else $error("always-flash not flash");
	a_default_stop: assert property (@(posedge ref_clk) disable iff (!rstN_q)
		(st_q == pmw_pkg::PMW_ST_DECIDE && orgC == pmw_pkg::PMW_ORG_DEFAULT)
		|=> cpuMode == pmw_pkg::PMW_STOP_DIS) else $error("default not stop-disabled");
endmodule

// ---- dv/pmw_cfg_model.sv ----
// Model of the stored power-up settings and the run/stop switch
`timescale 1ns/1ps
module pmw_cfg_model (
	// Clock
	input wire logic ref_clk,
	// Load request from the bench
	input wire logic loadCfg,
	input wire logic [15:0] newCfg,
	input wire logic [12:0] newWdog,
	// Settings towards the block
	output logic [1:0] flashSrc,
	output logic [1:0] ramSrc,
	output logic memPreserved,
	output logic ramHasConfig,
	output logic [1:0] powerupMode,
	output logic switchEnable,
	output logic [2:0] switchPos,
	output logic stopIoScanEn,
	output logic [2:0] savedMode,
	output logic [11:0] wdogTimeoutMs,
	output logic wdogUseDefault
);
	// ============================================================
	// Stored settings
	logic [15:0] cfg_q = 16'h0000;
	logic [12:0] wdog_q = 13'h01F4;

	// Settings survive power cycles, so they change only on an explicit load
	always @(posedge ref_clk) begin
		if (loadCfg) begin
			cfg_q <= newCfg;
			wdog_q <= newWdog;
		end
	end

	// Field unpacking, held stable through every decision window
	assign {flashSrc, ramSrc, memPreserved, ramHasConfig, powerupMode} = cfg_q[15:8];
	assign {switchEnable, switchPos, stopIoScanEn, savedMode} = cfg_q[7:0];
	// Timeout chosen by the bench well above its sweep spacing, leaving oversweep margin
	assign {wdogUseDefault, wdogTimeoutMs} = wdog_q;
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench sweeping every power-up setting combination except ramSrc 3, powerupMode 3, switchPos 3 to 7 and savedMode 4 to 7
`timescale 1ns/1ps
module testbench;
	// ============================================================
	// Signals
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic sweepStart = 1'b0;
	logic loadCfg = 1'b0;
	logic [15:0] newCfg = 16'h0000;
	logic [12:0] newWdog = 13'h01F4;
	// Millisecond tick shortened so the seconds, watchdog and blink timers are reached
	localparam int MS_CYCLES_SIM = 10;
	logic [1:0] flashSrc, ramSrc, powerupMode, origin;
	logic memPreserved, ramHasConfig, switchEnable, stopIoScanEn, wdogUseDefault;
	logic [2:0] switchPos, savedMode, cpuMode;
	logic [11:0] wdogTimeoutMs;
	logic decided, runProgram, ioScan, outputsEnabled, programmerOnly, healthLed, faultLog;
	logic [31:0] elapsedSec;
	int err_count = 0;
	int samples_checked = 0;

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	pmw_cfg_model pmw_cfg_model_i (.ref_clk(ref_clk), .loadCfg(loadCfg), .newCfg(newCfg), .newWdog(newWdog),
		.flashSrc(flashSrc), .ramSrc(ramSrc), .memPreserved(memPreserved), .ramHasConfig(ramHasConfig),
		.powerupMode(powerupMode), .switchEnable(switchEnable), .switchPos(switchPos),
		.stopIoScanEn(stopIoScanEn), .savedMode(savedMode), .wdogTimeoutMs(wdogTimeoutMs),
		.wdogUseDefault(wdogUseDefault));

	powerup_mode_watchdog #(.MS_CYCLES(MS_CYCLES_SIM)) powerup_mode_watchdog_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.flashSrc(flashSrc), .ramSrc(ramSrc), .memPreserved(memPreserved), .ramHasConfig(ramHasConfig),
		.powerupMode(powerupMode), .switchEnable(switchEnable), .switchPos(switchPos),
		.stopIoScanEn(stopIoScanEn), .savedMode(savedMode), .wdogTimeoutMs(wdogTimeoutMs),
		.wdogUseDefault(wdogUseDefault), .sweepStart(sweepStart), .decided(decided), .origin(origin),
		.cpuMode(cpuMode), .runProgram(runProgram), .ioScan(ioScan), .outputsEnabled(outputsEnabled),
		.programmerOnly(programmerOnly), .healthLed(healthLed), .faultLog(faultLog), .elapsedSec(elapsedSec));

	// ============================================================
	// Reference model of origin and mode
	function automatic logic [1:0] ref_origin(input logic [1:0] fs, input logic [1:0] rs, input logic mp,
		input logic rc);
		logic lostOrEmpty;
		lostOrEmpty = !mp || !rc;
		if (fs == pmw_pkg::PMW_SRC_ALWAYS_FLASH) return pmw_pkg::PMW_ORG_FLASH;
		if (fs == pmw_pkg::PMW_SRC_COND_FLASH) begin
			if (!mp) return pmw_pkg::PMW_ORG_FLASH;
			return rc ? pmw_pkg::PMW_ORG_RAM : pmw_pkg::PMW_ORG_DEFAULT;
		end
		if (lostOrEmpty) return pmw_pkg::PMW_ORG_DEFAULT;
		if (fs == pmw_pkg::PMW_SRC_ALWAYS_RAM && rs == pmw_pkg::PMW_SRC_ALWAYS_FLASH) return pmw_pkg::PMW_ORG_FLASH;
		return pmw_pkg::PMW_ORG_RAM;
	endfunction

	function automatic logic [2:0] ref_mode(input logic [1:0] org, input logic mp, input logic [1:0] pm,
		input logic se, input logic [2:0] sp, input logic sc, input logic [2:0] sv);
		logic [2:0] sw;
		logic [2:0] m;
		// Both stop codes of the switch rank as stop-enabled before the scan setting applies
		sw = (sp >= 3'h2) ? 3'(pmw_pkg::PMW_STOP_EN) : sp;
		if (org == pmw_pkg::PMW_ORG_DEFAULT) m = pmw_pkg::PMW_STOP_DIS;
		else if (org == pmw_pkg::PMW_ORG_FLASH || !mp) begin
			if (pm == pmw_pkg::PMW_PU_STOP || (se && sw == pmw_pkg::PMW_STOP_EN)) m = pmw_pkg::PMW_STOP_DIS;
			else if (!se || pm == pmw_pkg::PMW_PU_LAST) m = pmw_pkg::PMW_RUN_DIS;
			else m = sw;
		end else if (pm == pmw_pkg::PMW_PU_LAST) m = (se && sw > sv) ? sw : sv;
		else if (pm == pmw_pkg::PMW_PU_STOP) m = pmw_pkg::PMW_STOP_EN;
		else m = se ? sw : 3'(pmw_pkg::PMW_RUN_EN);
		if (m == pmw_pkg::PMW_STOP_EN && !sc) m = pmw_pkg::PMW_STOP_DIS;
		return m;
	endfunction

	// ============================================================
	// Compare and close
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One power cycle with given settings, then a sweep pulse
	task automatic power_up(input logic [15:0] c, input logic [1:0] eo, input logic [2:0] em);
		int n;
		@(negedge ref_clk);
		loadCfg = 1'b1;
		newCfg = c;
		reset_n = 1'b0;
		@(negedge ref_clk);
		loadCfg = 1'b0;
		@(negedge ref_clk);
		reset_n = 1'b1;
		n = 0;
		while (decided !== 1'b1 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		check(decided, 1, "decided");
		check(origin, eo, "origin");
		check(cpuMode, em, "mode");
		check(runProgram, em <= pmw_pkg::PMW_RUN_DIS, "runProgram");
		check(outputsEnabled, em == pmw_pkg::PMW_RUN_EN || em == pmw_pkg::PMW_STOP_EN, "outputsEnabled");
		check(ioScan, em <= pmw_pkg::PMW_STOP_EN, "ioScan");
		check(healthLed, 1, "led on");
		sweepStart = 1'b1;
		@(negedge ref_clk);
		sweepStart = 1'b0;
		@(negedge ref_clk);
		check(cpuMode, em, "mode after sweep");
		check({programmerOnly, faultLog}, 0, "halt flags");
		check(elapsedSec, 0, "elapsed");
	endtask

	// ============================================================
	// Main sequence over every settings word with ramSrc, powerupMode and switchPos below 3 and savedMode below 4
	initial begin
		logic [15:0] c;
		int n;
		repeat (2) @(negedge ref_clk);
		for (int i = 0; i < 65536; i++) begin
			c = 16'(i);
			if (c[13:12] == 2'h3 || c[9:8] == 2'h3 || c[6:4] == 3'h3 || c[6] || c[2]) continue;
			power_up(c, ref_origin(c[15:14], c[13:12], c[11], c[10]),
				ref_mode(ref_origin(c[15:14], c[13:12], c[11], c[10]), c[11], c[9:8], c[7], c[6:4], c[3], c[2:0]));
		end
		// Default 200 ms timeout; sweeps every 150 ms keep it quiet for over a second
		newWdog = 13'h1000;
		power_up(16'h5C00, pmw_pkg::PMW_ORG_RAM, pmw_pkg::PMW_RUN_EN);
		repeat (7) begin
			repeat (1500) @(negedge ref_clk);
			sweepStart = 1'b1;
			@(negedge ref_clk);
			sweepStart = 1'b0;
		end
		check(elapsedSec, 1, "one second");
		check(cpuMode, pmw_pkg::PMW_RUN_EN, "no early expiry");
		// Sweeps stop: expiry on the tick after the count reaches 200 ms
		n = 0;
		while (faultLog !== 1'b1 && n < 2100) begin
			@(negedge ref_clk);
			n++;
		end
		check(n >= 1995 && n <= 2015, 1, "expiry time");
		check(cpuMode, pmw_pkg::PMW_STOP_HALT, "halt mode");
		check({programmerOnly, outputsEnabled, runProgram, ioScan}, 4'h8, "halt outputs");
		@(negedge ref_clk);
		check(faultLog, 0, "fault one cycle");
		// Sweeps are ignored in halt while the light toggles every 250 ms
		sweepStart = 1'b1;
		@(negedge ref_clk);
		sweepStart = 1'b0;
		repeat (2600) @(negedge ref_clk);
		check({programmerOnly, healthLed}, 2'h2, "halt kept, led toggled");
		// Only a power cycle leaves halt, and the seconds restart
		newWdog = 13'h01F4;
		power_up(16'h5C00, pmw_pkg::PMW_ORG_RAM, pmw_pkg::PMW_RUN_EN);
		stop_test();
	end

	// Watchdog: the tests need about 77k cycles; give up after 90k
	initial begin
		#720000;
		err_count++;
		stop_test();
	end
endmodule
